// ---- hdl/alarm_route_pkg.sv ----
// Constants, register map and carrier types for the alarm routing bank.
// Assumes one 10 MHz core clock and a host-side decoder on the same clock.
package alarm_route_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_CLEAR_EN_LOW = 7'h18;
   localparam logic [6:0] ADDR_CLEAR_EN_HIGH = 7'h19;
   localparam logic [6:0] ADDR_CLEAR_SRC_ADC = 7'h1a;
   localparam logic [6:0] ADDR_CLEAR_SRC_MISC = 7'h1b;
   localparam logic [6:0] ADDR_OUT_SRC_ADC = 7'h1c;
   localparam logic [6:0] ADDR_OUT_SRC_MISC = 7'h1d;

   // Index of each register inside the bank
   localparam logic [2:0] IDX_CLEAR_EN_LOW = 3'h0;
   localparam logic [2:0] IDX_CLEAR_EN_HIGH = 3'h1;
   localparam logic [2:0] IDX_CLEAR_SRC_ADC = 3'h2;
   localparam logic [2:0] IDX_CLEAR_SRC_MISC = 3'h3;
   localparam logic [2:0] IDX_OUT_SRC_ADC = 3'h4;
   localparam logic [2:0] IDX_OUT_SRC_MISC = 3'h5;
   localparam int REG_COUNT = 6;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int ADC_SRC_MSB = 4;
   localparam int MISC_SRC_MSB = 3;
   localparam int LATCH_DIS_BIT = 4;
   localparam int DAC_CHANNELS = 16;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Alarm vector in register bit order (ADC 20..16, then misc 3..0)
   typedef struct packed {
      logic [4:0] adc;      // Input 20 alarm down to input 16 alarm
      logic alarm_input;    // Alarm input pin alarm
      logic thermal;        // Thermal alarm
      logic temp_high;      // Local temperature high alarm
      logic temp_low;       // Local temperature low alarm
   } alarm_vec_s;

   // Register access from the serial host decoder
   typedef struct packed {
      logic wr_en;          // One-cycle write strobe
      logic rd_en;          // One-cycle read strobe
      logic [6:0] addr;     // Register address
      logic [7:0] wdata;    // Write data
   } reg_req_s;

endpackage : alarm_route_pkg

// ---- hdl/dac_clear_alarm_routing.sv ----
// Routing bank: alarms to DAC clear lines and to the alarm output pin.
// Assumes alarm flags and register strobes come from same-clock logic.
`timescale 1ns/1ns
module dac_clear_alarm_routing
   import alarm_route_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire reg_req_s reg_req_in,
   output logic [7:0] reg_rdata_out,
   input wire alarm_vec_s alarms_in,
   input wire logic alarm_output_pin_select_in,
   input wire logic general_pin_one_in,
   output logic [DAC_CHANNELS-1:0] dac_clear_out,
   output logic alarm_output_pin_out,
   output logic alarm_latch_disable_out
);

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   logic [7:0] route_reg [0:REG_COUNT-1]; // Routing registers
   logic [6:0] offs;                      // Address minus bank base
   logic [2:0] idx;                       // Register index
   logic hit;                             // Address inside the bank

   assign offs = reg_req_in.addr - ADDR_CLEAR_EN_LOW;
   assign idx = offs[2:0];
   assign hit = (reg_req_in.addr >= ADDR_CLEAR_EN_LOW) &&
                (reg_req_in.addr <= ADDR_OUT_SRC_MISC);

   // Register writes, one process per register
   generate
      for (genvar r = 0; r < REG_COUNT; r++) begin : g_reg
         always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) begin
               route_reg[r] <= REG_RESET;
            end else if (reg_req_in.wr_en && hit &&
                         idx == 3'(r)) begin
               route_reg[r] <= reg_req_in.wdata;
            end
         end
      end
   endgenerate

   // Read port: answer one cycle after the strobe, held until next read
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= READ_UNMAPPED;
      end else if (reg_req_in.rd_en) begin
         if (hit) begin
            reg_rdata_out <= route_reg[idx];
         end else begin
            reg_rdata_out <= READ_UNMAPPED;
         end
      end
   end

   // ----------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------
   logic [DAC_CHANNELS-1:0] clear_en;  // Per-channel clear enables
   alarm_vec_s clear_sel;              // Alarms chosen as clear sources
   alarm_vec_s out_sel;                // Alarms chosen for the pin
   logic clear_event;                  // Some selected alarm is active
   logic alarm_active;                 // Some routed alarm is active

   // Channels 15..8 high register, 7..0 low register
   assign clear_en = {route_reg[IDX_CLEAR_EN_HIGH],
                      route_reg[IDX_CLEAR_EN_LOW]};
   // ADC inputs 20..16 then the four misc alarms
   assign clear_sel = alarm_vec_s'({
      route_reg[IDX_CLEAR_SRC_ADC][ADC_SRC_MSB:0],
      route_reg[IDX_CLEAR_SRC_MISC][MISC_SRC_MSB:0]});
   assign out_sel = alarm_vec_s'({
      route_reg[IDX_OUT_SRC_ADC][ADC_SRC_MSB:0],
      route_reg[IDX_OUT_SRC_MISC][MISC_SRC_MSB:0]});
   // Independent of DAC operating mode: no mode term enters here
   assign clear_event = |(alarms_in & clear_sel);
   assign alarm_active = |(alarms_in & out_sel);

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Clear lines follow the event level; released when it drops
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dac_clear_out <= '0;
      end else if (clear_event) begin
         dac_clear_out <= clear_en;
      end else begin
         dac_clear_out <= '0;
      end
   end

   // Pin shows routed alarms only in alarm-output function
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         alarm_output_pin_out <= 1'b0;
      end else if (alarm_output_pin_select_in) begin
         alarm_output_pin_out <= alarm_active;
      end else begin
         alarm_output_pin_out <= general_pin_one_in;
      end
   end

   // Latch disable bit handed to the alarm latching logic
   assign alarm_latch_disable_out =
      route_reg[IDX_OUT_SRC_MISC][LATCH_DIS_BIT];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   property p_clear_enabled;
      clear_event |=> dac_clear_out == $past(clear_en);
   endproperty
   a_clear_enabled: assert property (p_clear_enabled)
      else $error("enabled channel not cleared on clear event");

   property p_clear_disabled;
      1'b1 |=> (dac_clear_out & ~$past(clear_en)) == 16'h0000;
   endproperty
   a_clear_disabled: assert property (p_clear_disabled)
      else $error("disabled channel cleared");

   property p_low_map;
      (reg_req_in.wr_en && reg_req_in.addr == ADDR_CLEAR_EN_LOW)
         |=> clear_en[7:0] == $past(reg_req_in.wdata);
   endproperty
   a_low_map: assert property (p_low_map)
      else $error("low enable register mapped wrong");

   property p_high_map;
      (reg_req_in.wr_en && reg_req_in.addr == ADDR_CLEAR_EN_HIGH)
         |=> clear_en[15:8] == $past(reg_req_in.wdata);
   endproperty
   a_high_map: assert property (p_high_map)
      else $error("high enable register mapped wrong");

   property p_adc_source;
      (alarms_in.adc[0] && clear_sel.adc[0])
         |=> dac_clear_out == $past(clear_en);
   endproperty
   a_adc_source: assert property (p_adc_source)
      else $error("input 16 alarm did not clear");

   property p_thermal_source;
      (alarms_in.thermal && clear_sel.thermal)
         |=> dac_clear_out == $past(clear_en);
   endproperty
   a_thermal_source: assert property (p_thermal_source)
      else $error("thermal alarm did not clear");

   property p_release;
      (!clear_event)[*2] |=> dac_clear_out == 16'h0000;
   endproperty
   a_release: assert property (p_release)
      else $error("clear held without event");

   property p_pin_alarm;
      (alarm_output_pin_select_in && alarm_active)
         |=> alarm_output_pin_out;
   endproperty
   a_pin_alarm: assert property (p_pin_alarm)
      else $error("routed alarm missing on pin");

   property p_pin_general;
      !alarm_output_pin_select_in
         |=> alarm_output_pin_out == $past(general_pin_one_in);
   endproperty
   a_pin_general: assert property (p_pin_general)
      else $error("pin not in general function");

   property p_readback;
      (reg_req_in.wr_en && hit) ##1 !reg_req_in.wr_en ##1
         (reg_req_in.rd_en && !reg_req_in.wr_en &&
         reg_req_in.addr == $past(reg_req_in.addr, 2))
         |=> reg_rdata_out == $past(reg_req_in.wdata, 3);
   endproperty
   a_readback: assert property (p_readback)
      else $error("read value differs from last write");

   // Routed input 20 alarm reaches the pin
   property p_out_adc_source;
      (alarm_output_pin_select_in && alarms_in.adc[4] && out_sel.adc[4])
         |=> alarm_output_pin_out;
   endproperty
   a_out_adc_source: assert property (p_out_adc_source)
      else $error("input 20 alarm missing on pin");

   // Routed alarm input alarm reaches the pin
   property p_out_misc_source;
      (alarm_output_pin_select_in && alarms_in.alarm_input &&
       out_sel.alarm_input) |=> alarm_output_pin_out;
   endproperty
   a_out_misc_source: assert property (p_out_misc_source)
      else $error("alarm input alarm missing on pin");

   // Unrouted alarms leave the pin low
   property p_pin_quiet;
      (alarm_output_pin_select_in && !alarm_active)
         |=> !alarm_output_pin_out;
   endproperty
   a_pin_quiet: assert property (p_pin_quiet)
      else $error("pin raised without a routed alarm");

   // Field views, clear lines and pin all zero on the edge that leaves reset
   property p_reset_zero;
      disable iff (1'b0)
      $fell(rst_in) |-> (clear_sel == '0 && out_sel == '0 &&
         clear_en == '0 && dac_clear_out == '0 && !alarm_output_pin_out);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("routing state not zero after reset");

   c_clear: cover property (clear_event ##1 (dac_clear_out != '0));
   c_pin: cover property (alarm_output_pin_select_in && alarm_active);
   c_read: cover property (reg_req_in.rd_en && hit);
   c_release: cover property (
      (dac_clear_out != '0) ##1 (dac_clear_out == '0));
   c_general: cover property (
      !alarm_output_pin_select_in && general_pin_one_in);

endmodule : dac_clear_alarm_routing

// ---- test/host_model.sv ----
// Host controller model on the same-clock register strobe port.
// Assumes one bench process calls its tasks, never two at once.
`timescale 1ns/1ns
module host_model
   import alarm_route_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic [7:0] rdata_in,
   output reg_req_s req_out
);
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   initial req_out = '0;

   // Write strobe held until the taking edge; reserved bits kept zero
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = (a >= 7'h1a && a <= 7'h1d) ? ((a == 7'h1b) ? 8'h0f : 8'h1f)
         : 8'hff;
      @(posedge core_clk_in) #10;
      req_out = '{1'b1, 1'b0, a, d & m};
      @(posedge core_clk_in) #10;
      req_out.wr_en = 1'b0;
   endtask : wr

   // Read strobe; data taken after the answering edge
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge core_clk_in) #10;
      req_out = '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk_in) #10;
      d = rdata_in;
      req_out.rd_en = 1'b0;
   endtask : rd
endmodule : host_model

// ---- test/tb.sv ----
// Self-checking bench for the alarm routing bank.
// Assumes the host model drives every register access.
`timescale 1ns/1ns
module tb import alarm_route_pkg::*;;
   logic core_clk_in, rst_in, sel, gen, pin, ld;
   alarm_vec_s alarms;
   reg_req_s req;
   logic [7:0] rdata, rv;
   logic [15:0] clr;
   logic [8:0] m;
   int error_cnt = 0, samples_checked = 0, cycles = 0;

   // ----------------------------------------------------------------
   // Design and host
   // ----------------------------------------------------------------
   dac_clear_alarm_routing DUT (.core_clk_in(core_clk_in),
      .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
      .alarms_in(alarms), .alarm_output_pin_select_in(sel),
      .general_pin_one_in(gen), .dac_clear_out(clr),
      .alarm_output_pin_out(pin), .alarm_latch_disable_out(ld));
   host_model host (.core_clk_in(core_clk_in), .rdata_in(rdata),
      .req_out(req));

   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   // Hang guard
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic tick();
      repeat (2) @(posedge core_clk_in);
      #10;
   endtask : tick

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      for (int a = 8'h18; a <= 8'h1e; a++) begin
         host.rd(a[6:0], rv);
         chk({8'h00, rv}, 16'h0000);
      end
      chk(clr, 16'h0000);
      chk({15'h0000, pin}, 16'h0000);
      chk({15'h0000, ld}, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_readback();
      host.wr(7'h18, 8'ha5);
      host.wr(7'h19, 8'h3c);
      host.wr(7'h1a, 8'hff);
      host.rd(7'h18, rv);
      chk({8'h00, rv}, 16'h00a5);
      host.rd(7'h19, rv);
      chk({8'h00, rv}, 16'h003c);
      host.rd(7'h1a, rv);
      chk({8'h00, rv}, 16'h001f);
      host.wr(7'h1d, 8'h10);
      host.rd(7'h1d, rv);
      chk({8'h00, rv}, 16'h0010);
      chk({15'h0000, ld}, 16'h0001);
      $display("test readback done");
   endtask : t_readback

   task automatic t_clear();
      for (int i = 0; i < 9; i++) begin
         m = 9'h001 << i;
         host.wr(7'h1a, {3'b000, m[8:4]});
         host.wr(7'h1b, {4'h0, m[3:0]});
         alarms = ~m;
         tick();
         chk(clr, 16'h0000);
         alarms = m;
         tick();
         chk(clr, 16'h3ca5);
         tick();
         chk(clr, 16'h3ca5);
         alarms = '0;
         tick();
         chk(clr, 16'h0000);
      end
      $display("test clear done");
   endtask : t_clear

   task automatic t_pin();
      for (int i = 0; i < 9; i++) begin
         m = 9'h001 << i;
         host.wr(7'h1c, {3'b000, m[8:4]});
         host.wr(7'h1d, {4'h0, m[3:0]});
         sel = 1'b1;
         alarms = ~m;
         tick();
         chk({15'h0000, pin}, 16'h0000);
         alarms = m;
         tick();
         chk({15'h0000, pin}, 16'h0001);
         sel = 1'b0;
         tick();
         chk({15'h0000, pin}, 16'h0000);
         gen = 1'b1;
         alarms = '0;
         tick();
         chk({15'h0000, pin}, 16'h0001);
         gen = 1'b0;
      end
      $display("test pin done");
   endtask : t_pin

   initial begin
      rst_in = 1'b1;
      sel = 1'b0;
      gen = 1'b0;
      alarms = '0;
      repeat (12) @(posedge core_clk_in);
      #10 rst_in = 1'b0;
      t_reset();
      t_readback();
      t_clear();
      t_pin();
      summarize();
   end
endmodule : tb
